// [rtl/pbgpio_pkg.sv]
// package: register map, reset values and field positions of the port b gpio block
package pbgpio_pkg;
  localparam int ADDR_W = 20;
  localparam logic [19:0] OFS_DIRECTION = 20'hee00a;
  localparam logic [19:0] OFS_OUT_LATCH = 20'hfffda;
  localparam logic [19:0] OFS_ALT_ENABLE = 20'hee100;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_OUT_LATCH = 8'h00;
  localparam logic [7:0] RD_DIRECTION = 8'hff;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam int PAT_LO_BIT = 4;
  localparam int TMR_HI_BIT = 3;
  localparam int SYNC_STAGES = 3;
endpackage

// [rtl/pbgpio_sync.sv]
// three-stage pin input synchroniser with agreement filter
module pbgpio_sync (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // raw pin level and filtered level
  input wire logic [7:0] pin_in,
  output logic [7:0] level
);
  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] stage3;

  // shift chain; first stage read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= 8'h00;
      stage2 <= 8'h00;
      stage3 <= 8'h00;
    end else if (ce) begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit changes only when stages two and three agree, so one-cycle glitches are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 8'h00;
    end else if (ce) begin
      for (int i = 0; i < 8; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule // pbgpio_sync

// [rtl/pbgpio_port.sv]
// top: eight-pin general purpose port with pattern and timer/chip-select muxing
//
// Implementation choice: strobed register access.
module pbgpio_port (
  // clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // power state
  input wire logic HW_STANDBY,
  input wire logic SW_STANDBY,
  // register port
  input wire logic [19:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // pattern controller
  input wire logic [3:0] PATTERN_ENABLE_UPPER_BYTE,
  input wire logic [7:0] PATTERN_OUT,
  // lower-pin alternate functions: timer and chip select
  input wire logic [3:0] ALT_LOW_ENABLE,
  input wire logic [3:0] ALT_LOW_OUT,
  // pins
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE_N
);
  logic [7:0] port_direction_select;
  logic [7:0] port_output_latch;
  logic [7:0] pin_level;
  logic [7:0] pattern_enable_full;
  logic [7:0] alt_enable_full;
  logic [7:0] alt_out_full;
  logic [7:0] next_pin_out;
  logic [7:0] next_oe_n;
  logic [7:0] next_rdata;
  logic clear_regs;

  // hardware standby behaves like reset for the direction and latch registers; software standby changes nothing
  assign clear_regs = SYS_RST | HW_STANDBY;

  // address decoder shared by read and write paths
  function automatic logic hit(input logic [19:0] a, input logic [19:0] ofs);
    hit = (a == ofs);
  endfunction

  // pin synchroniser
  pbgpio_sync u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .pin_in(PIN_IN),
    .level(pin_level)
  );

  // direction register, write-only
  always_ff @(posedge CLK_SYS) begin
    if (clear_regs) begin
      port_direction_select <= pbgpio_pkg::RST_DIRECTION;
    end else if (CLK_EN && REG_WR && hit(REG_ADDR, pbgpio_pkg::OFS_DIRECTION)) begin
      port_direction_select <= REG_WDATA;
    end
  end

  // output latch; software standby leaves it untouched
  always_ff @(posedge CLK_SYS) begin
    if (clear_regs) begin
      port_output_latch <= pbgpio_pkg::RST_OUT_LATCH;
    end else if (CLK_EN && REG_WR && hit(REG_ADDR, pbgpio_pkg::OFS_OUT_LATCH)) begin
      port_output_latch <= REG_WDATA;
    end
  end

  // pattern enables only exist for the upper nibble
  assign pattern_enable_full = {PATTERN_ENABLE_UPPER_BYTE, 4'h0};

  // low-pin claims widened so the mux loop never indexes past the four claim bits
  assign alt_enable_full = {4'h0, ALT_LOW_ENABLE};
  assign alt_out_full = {4'h0, ALT_LOW_OUT};

  // per-pin mux: alternate low functions win, then pattern, then plain port
  always_comb begin
    next_pin_out = 8'h00;
    next_oe_n = 8'hff;
    for (int i = 0; i < 8; i++) begin
      if (alt_enable_full[i]) begin
        next_pin_out[i] = alt_out_full[i];
        next_oe_n[i] = 1'b0;
      end else if (port_direction_select[i] && pattern_enable_full[i]) begin
        next_pin_out[i] = PATTERN_OUT[i];
        next_oe_n[i] = 1'b0;
      end else if (port_direction_select[i]) begin
        next_pin_out[i] = port_output_latch[i];
        next_oe_n[i] = 1'b0;
      end
    end
    if (clear_regs) begin
      next_oe_n = 8'hff;
      next_pin_out = 8'h00;
    end
  end

  // pin drivers registered so data outputs come from flip-flops
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PIN_OUT <= 8'h00;
      PIN_OE_N <= 8'hff;
    end else if (CLK_EN) begin
      PIN_OUT <= next_pin_out;
      PIN_OE_N <= next_oe_n;
    end
  end

  // read mux; direction register never reveals its contents
  always_comb begin
    if (hit(REG_ADDR, pbgpio_pkg::OFS_DIRECTION)) begin
      next_rdata = pbgpio_pkg::RD_DIRECTION;
    end else if (hit(REG_ADDR, pbgpio_pkg::OFS_OUT_LATCH)) begin
      next_rdata = (port_direction_select & port_output_latch)
                 | (~port_direction_select & pin_level);
    end else begin
      next_rdata = pbgpio_pkg::RD_UNMAPPED;
    end
  end

  // read data stands one cycle after an enabled strobe, zero after other enabled cycles, held while CLK_EN is low
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (CLK_EN) begin
      REG_RDATA <= REG_RD ? next_rdata : 8'h00;
    end
  end

  // checks
  a_dir_reads_ones: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && REG_RD && REG_ADDR == pbgpio_pkg::OFS_DIRECTION) |=> REG_RDATA == 8'hff)
    else $error("direction read not all ones");
  a_dir_clear: assert property (@(posedge CLK_SYS)
    (HW_STANDBY || SYS_RST) |=> port_direction_select == 8'h00)
    else $error("direction not cleared");
  a_latch_clear: assert property (@(posedge CLK_SYS)
    (HW_STANDBY || SYS_RST) |=> port_output_latch == 8'h00)
    else $error("latch not cleared");
  a_latch_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || HW_STANDBY)
    (CLK_EN && REG_WR && REG_ADDR == pbgpio_pkg::OFS_OUT_LATCH) |=> port_output_latch == $past(REG_WDATA))
    else $error("latch write lost");
  a_swstby_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || HW_STANDBY)
    (SW_STANDBY && !REG_WR) |=> $stable(port_direction_select))
    else $error("direction changed in software standby");
  a_input_hiz: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[7] == 1'b0) |=> PIN_OE_N[7])
    else $error("input pin driven");
  a_pattern_pin7: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[7] && PATTERN_ENABLE_UPPER_BYTE[3])
      |=> (!PIN_OE_N[7] && PIN_OUT[7] == $past(PATTERN_OUT[7])))
    else $error("pin 7 pattern not driven");
  a_port_pin4: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[4] && !PATTERN_ENABLE_UPPER_BYTE[0])
      |=> (!PIN_OE_N[4] && PIN_OUT[4] == $past(port_output_latch[4])))
    else $error("pin 4 port output wrong");
  a_read_latched: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && REG_RD && REG_ADDR == pbgpio_pkg::OFS_OUT_LATCH && port_direction_select == 8'hff)
      |=> REG_RDATA == $past(port_output_latch))
    else $error("read did not return latch");

  // register writes, standby holds and clock-enable freeze
  a_dir_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || HW_STANDBY)
    (CLK_EN && REG_WR && REG_ADDR == pbgpio_pkg::OFS_DIRECTION) |=> port_direction_select == $past(REG_WDATA))
    else $error("direction write lost");
  a_latch_swstby: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || HW_STANDBY)
    (SW_STANDBY && !REG_WR) |=> $stable(port_output_latch))
    else $error("latch changed in software standby");
  a_stray_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || HW_STANDBY)
    (CLK_EN && REG_WR && REG_ADDR != pbgpio_pkg::OFS_OUT_LATCH && REG_ADDR != pbgpio_pkg::OFS_DIRECTION)
      |=> ($stable(port_output_latch) && $stable(port_direction_select)))
    else $error("unmapped write changed a register");
  a_freeze_dir: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || HW_STANDBY)
    !CLK_EN |=> $stable(port_direction_select))
    else $error("direction changed while frozen");
  a_freeze_latch: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || HW_STANDBY)
    !CLK_EN |=> $stable(port_output_latch))
    else $error("latch changed while frozen");
  a_freeze_pins: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !CLK_EN |=> ($stable(PIN_OE_N) && $stable(PIN_OUT)))
    else $error("pins changed while frozen");

  // upper pins released as inputs, pattern enable or not
  a_input_hiz6: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[6] == 1'b0)
      |=> PIN_OE_N[6])
    else $error("input pin 6 driven");
  a_input_hiz5: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[5] == 1'b0)
      |=> PIN_OE_N[5])
    else $error("input pin 5 driven");
  a_input_hiz4: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[4] == 1'b0)
      |=> PIN_OE_N[4])
    else $error("input pin 4 driven");
  a_pattern_off7: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !port_direction_select[7] && PATTERN_ENABLE_UPPER_BYTE[3])
      |=> PIN_OE_N[7])
    else $error("pin 7 pattern driven without direction");
  a_pattern_off5: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !port_direction_select[5] && PATTERN_ENABLE_UPPER_BYTE[1])
      |=> PIN_OE_N[5])
    else $error("pin 5 pattern driven without direction");

  // upper pins as port outputs
  a_port_pin7: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[7] && !PATTERN_ENABLE_UPPER_BYTE[3])
      |=> (!PIN_OE_N[7] && PIN_OUT[7] == $past(port_output_latch[7])))
    else $error("pin 7 port output wrong");
  a_port_pin6: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[6] && !PATTERN_ENABLE_UPPER_BYTE[2])
      |=> (!PIN_OE_N[6] && PIN_OUT[6] == $past(port_output_latch[6])))
    else $error("pin 6 port output wrong");
  a_port_pin5: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[5] && !PATTERN_ENABLE_UPPER_BYTE[1])
      |=> (!PIN_OE_N[5] && PIN_OUT[5] == $past(port_output_latch[5])))
    else $error("pin 5 port output wrong");

  // upper pins carrying pattern bits
  a_pattern_pin6: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[6] && PATTERN_ENABLE_UPPER_BYTE[2])
      |=> (!PIN_OE_N[6] && PIN_OUT[6] == $past(PATTERN_OUT[6])))
    else $error("pin 6 pattern not driven");
  a_pattern_pin5: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[5] && PATTERN_ENABLE_UPPER_BYTE[1])
      |=> (!PIN_OE_N[5] && PIN_OUT[5] == $past(PATTERN_OUT[5])))
    else $error("pin 5 pattern not driven");
  a_pattern_pin4: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && port_direction_select[4] && PATTERN_ENABLE_UPPER_BYTE[0])
      |=> (!PIN_OE_N[4] && PIN_OUT[4] == $past(PATTERN_OUT[4])))
    else $error("pin 4 pattern not driven");

  // lower pins: timer or chip-select claim first, then port output, then input
  a_alt_pin0: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && ALT_LOW_ENABLE[0])
      |=> (!PIN_OE_N[0] && PIN_OUT[0] == $past(ALT_LOW_OUT[0])))
    else $error("pin 0 claim not driven");
  a_alt_pin1: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && ALT_LOW_ENABLE[1])
      |=> (!PIN_OE_N[1] && PIN_OUT[1] == $past(ALT_LOW_OUT[1])))
    else $error("pin 1 claim not driven");
  a_low_port0: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !ALT_LOW_ENABLE[0] && port_direction_select[0])
      |=> (!PIN_OE_N[0] && PIN_OUT[0] == $past(port_output_latch[0])))
    else $error("pin 0 port output wrong");
  a_low_port1: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !ALT_LOW_ENABLE[1] && port_direction_select[1])
      |=> (!PIN_OE_N[1] && PIN_OUT[1] == $past(port_output_latch[1])))
    else $error("pin 1 port output wrong");
  a_low_port2: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !ALT_LOW_ENABLE[2] && port_direction_select[2])
      |=> (!PIN_OE_N[2] && PIN_OUT[2] == $past(port_output_latch[2])))
    else $error("pin 2 port output wrong");
  a_low_port3: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !ALT_LOW_ENABLE[3] && port_direction_select[3])
      |=> (!PIN_OE_N[3] && PIN_OUT[3] == $past(port_output_latch[3])))
    else $error("pin 3 port output wrong");
  a_low_input0: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !ALT_LOW_ENABLE[0] && !port_direction_select[0])
      |=> PIN_OE_N[0])
    else $error("input pin 0 driven");
  a_low_input1: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !ALT_LOW_ENABLE[1] && !port_direction_select[1])
      |=> PIN_OE_N[1])
    else $error("input pin 1 driven");
  a_low_input2: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !ALT_LOW_ENABLE[2] && !port_direction_select[2])
      |=> PIN_OE_N[2])
    else $error("input pin 2 driven");
  a_low_input3: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && !HW_STANDBY && !ALT_LOW_ENABLE[3] && !port_direction_select[3])
      |=> PIN_OE_N[3])
    else $error("input pin 3 driven");

  // read-back of pin levels and release on reset or hardware standby
  a_read_pins: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN && REG_RD && REG_ADDR == pbgpio_pkg::OFS_OUT_LATCH && port_direction_select == 8'h00)
      |=> REG_RDATA == $past(pin_level))
    else $error("read did not return pin level");
  a_pins_released: assert property (@(posedge CLK_SYS)
    (SYS_RST || (CLK_EN && HW_STANDBY)) |=> PIN_OE_N == 8'hff)
    else $error("pins not released");
endmodule // pbgpio_port

// [bench/pbgpio_board.sv]
// board-side model of the circuitry that sits on the eight port pins
module pbgpio_board (
  // port side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  // level the board puts on pins the port has released
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  // a driven pin reads back its own drive, so the port never fights the board
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule // pbgpio_board

// [bench/tb_pbgpio_port.sv]
// testbench for the port b gpio block: register access, pin muxing, standby
module tb_pbgpio_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, hws = 1'h0, sws = 1'h0, wr_s = 1'h0, rd_s = 1'h0, ce = 1'h1;
  logic [19:0] addr = 20'h00000;
  logic [7:0] wd = 8'h00, pat = 8'h00, ext = 8'h3c;
  logic [3:0] pen = 4'h0, aen = 4'h0, aout = 4'h0;
  logic [7:0] rdata, pout, oen, pin;
  int n_mismatch = 0, n_compared = 0;
  localparam logic [19:0] DIR = pbgpio_pkg::OFS_DIRECTION;
  localparam logic [19:0] LAT = pbgpio_pkg::OFS_OUT_LATCH;

  always #5 clk = ~clk;

  pbgpio_port u_pbgpio_port (.CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(ce), .HW_STANDBY(hws), .SW_STANDBY(sws),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
    .PATTERN_ENABLE_UPPER_BYTE(pen), .PATTERN_OUT(pat), .ALT_LOW_ENABLE(aen), .ALT_LOW_OUT(aout),
    .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE_N(oen));
  pbgpio_board u_pbgpio_board (.pin_out(pout), .pin_oe_n(oen), .ext_level(ext), .pin_in(pin));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [19:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    #1 chk(nm, e, rdata);
  endtask

  // only the output values of driven pins are compared
  task automatic pins(input logic [7:0] eo, input logic [7:0] ee, input string nm);
    repeat (3) @(posedge clk);
    #1 chk({nm, " oe_n"}, ee, oen);
    chk({nm, " out"}, eo, pout & ~ee);
    $display("test %s done", nm);
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    rd(DIR, 8'hff, "dir read");
    pins(8'h00, 8'hff, "reset pins");
    rd(LAT, 8'h3c, "reset pin read");
    wr(DIR, 8'hff);
    rd(LAT, 8'h00, "latch reset");
    wr(LAT, 8'h5a);
    wr(DIR, 8'hf0);
    pins(8'h50, 8'h0f, "plain io");
    repeat (4) @(posedge clk);
    rd(LAT, 8'h5c, "mixed read");
    // a write while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'h0;
    wr(LAT, 8'hff);
    ce <= 1'h1;
    rd(LAT, 8'h5c, "freeze read");
    @(posedge clk);
    pen <= 4'h5;
    pat <= 8'h0f;
    pins(8'h00, 8'h0f, "pattern even");
    @(posedge clk);
    pen <= 4'ha;
    pat <= 8'ha0;
    pins(8'hf0, 8'h0f, "pattern odd");
    wr(DIR, 8'h00);
    pins(8'h00, 8'hff, "pattern input");
    @(posedge clk);
    aen <= 4'h3;
    aout <= 4'h1;
    pins(8'h01, 8'hfc, "low alt");
    repeat (3) @(posedge clk);
    rd(LAT, 8'h3d, "alt read");
    wr(DIR, 8'hff);
    @(posedge clk);
    aen <= 4'h0;
    sws <= 1'h1;
    pins(8'hfa, 8'h00, "sw standby");
    rd(LAT, 8'h5a, "sw standby read");
    @(posedge clk);
    hws <= 1'h1;
    @(posedge clk);
    hws <= 1'h0;
    sws <= 1'h0;
    pins(8'h00, 8'hff, "hw standby");
    // latch only readable with direction set, pins read back otherwise
    wr(DIR, 8'hff);
    rd(LAT, 8'h00, "hw standby read");
    wr(LAT, 8'h3c);
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    pins(8'h00, 8'hff, "mid reset");
    wr(DIR, 8'hff);
    wr(20'h00000, 8'hff);
    rd(LAT, 8'h00, "mid reset latch");
    rd(20'h00000, pbgpio_pkg::RD_UNMAPPED, "unmapped");
    end_of_test;
  end

  // whole sequence needs about 95 cycles
  initial begin
    repeat (1000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
endmodule // tb_pbgpio_port
